// File: hdl/core_state_pkg.sv
// Constants, field layouts and carrier types for the core state block
package core_state_pkg;

  // Address map boundaries
  localparam logic [15:0] PERIPH_LAST     = 16'h007f;
  localparam logic [15:0] RAM_FIRST       = 16'h0080;
  localparam logic [15:0] RAM_LAST_SMALL  = 16'h027f;
  localparam logic [15:0] RAM_LAST_LARGE  = 16'h047f;
  localparam logic [15:0] ROM_FIRST_MASK  = 16'he000;
  localparam logic [15:0] ROM_FIRST_OTP   = 16'hc000;
  localparam logic [15:0] ROM_FIRST_EXT   = 16'h8000;
  localparam logic [15:0] BANK_BASE       = 16'h0100;

  // Reset values and bank count limits
  localparam logic [15:0] PC_RESET        = 16'hfffd;
  localparam logic [1:0]  IL_RESET        = 2'h3;
  localparam logic [4:0]  BANKS_SMALL_MAX = 5'h0f;
  localparam logic [4:0]  BANKS_LARGE_MAX = 5'h1f;

  // Condition flag bit positions within the low status byte
  localparam int FLAG_H  = 7;
  localparam int FLAG_I  = 6;
  localparam int FLAG_IL = 4;
  localparam int FLAG_N  = 3;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_V  = 1;
  localparam int FLAG_C  = 0;

  // Register port indices (own choice)
  localparam logic [3:0] IDX_PC  = 4'h0;
  localparam logic [3:0] IDX_ACC = 4'h1;
  localparam logic [3:0] IDX_TMP = 4'h2;
  localparam logic [3:0] IDX_INDEX = 4'h3;
  localparam logic [3:0] IDX_EXTRA = 4'h4;
  localparam logic [3:0] IDX_SP  = 4'h5;
  localparam logic [3:0] IDX_PSW = 4'h6;
  localparam logic [3:0] IDX_MAP = 4'h7;

  typedef enum logic [2:0] {
    REGION_PERIPH = 3'h0,
    REGION_RAM    = 3'h1,
    REGION_ROM    = 3'h2,
    REGION_NONE   = 3'h3
  } region_e;

  typedef enum logic [2:0] {
    ALU_NOP = 3'h0,
    ALU_ADD = 3'h1,
    ALU_SUB = 3'h2,
    ALU_SHL = 3'h3,
    ALU_SHR = 3'h4
  } alu_op_e;

  typedef enum logic [1:0] {
    VAR_MASK = 2'h0,
    VAR_OTP  = 2'h1,
    VAR_EXT  = 2'h2
  } variant_e;

  typedef struct packed {
    logic       h;
    logic       i;
    logic [1:0] il;
    logic       n;
    logic       z;
    logic       v;
    logic       c;
  } flags_s;

  typedef struct packed {
    region_e    region;
    logic [15:0] offset;
  } decode_s;

endpackage

// File: hdl/core_state.sv
// Core architectural registers, flag logic, interrupt gate and address decode
//
// Contract
// RULE1: Decode one flat 16-bit, 64 KB address space for all regions.
// RULE2: Below 007F is peripheral; 0080 to 027F RAM, or 047F on large RAM.
// RULE3: ROM starts at E000, C000 or 8000 by variant.
// RULE4: Vectors sit at the top; reset loads program counter with FFFD.
// RULE5: Program counter is 16 bits and addresses the next fetch.
// RULE6: Work accumulator is 16 bits; byte operations touch only its low byte.
// RULE7: Second accumulator is the other operand; byte ops use low byte.
// RULE8: Index register is 16 bits, undefined at reset.
// RULE9: Extra pointer and stack pointer are 16 bits, undefined at reset.
// RULE10: Status word high byte is bank pointer, low byte condition flags.
// RULE11: Half-carry set on carry or borrow between bits 3 and 4.
// RULE12: Interrupt enable permits when one, blocks when zero, cleared by reset.
// RULE13: Level mask resets to 11; service only strictly higher priority.
// RULE14: Negative flag follows the result's top bit; word ops here take bit 7.
// RULE15: Zero flag set for zero result, cleared otherwise; word ops here test only the low byte.
// RULE16: Overflow flag set on two's-complement overflow, else cleared; word ops here flag byte overflow at bit 7 only.
// RULE17: Carry set on carry or borrow out of bit 7; shifts take shifted bit.
// RULE18: Banks of eight 8-bit registers in RAM; 16 banks on 512-byte RAM.
// RULE19: Large RAM variant allows up to 32 banks.
// RULE20: Register RAM address is base plus bank times eight plus number.
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module core_state
  import core_state_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  // Variant straps, static
  input  wire variant_e    rom_variant,
  input  wire logic        large_ram,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // Program counter advance from the fetch unit
  input  wire logic        pc_step,
  // Arithmetic request
  input  wire logic        alu_go,
  input  wire alu_op_e     alu_op,
  input  wire logic        alu_word,
  // Address decode request
  input  wire logic [15:0] mem_addr,
  output var decode_s      mem_decode,
  // General-purpose register address
  input  wire logic [2:0]  gpr_num,
  output logic [15:0]      gpr_addr,
  // Interrupt gate
  input  wire logic        irq_req,
  input  wire logic [1:0]  irq_level,
  output logic             irq_take,
  output var flags_s       flags
);

  logic [15:0] program_counter_ff;
  logic [15:0] work_accumulator_ff;
  logic [15:0] second_operand_ff;
  logic [15:0] index_register_ff;
  logic [15:0] extra_memory_pointer_ff;
  logic [15:0] stack_top_pointer_ff;
  logic [7:0]  bank_select_pointer_ff;
  flags_s      condition_flags_ff;
  logic [15:0] nxt_acc;
  flags_s      nxt_flags;

  // Region lookup, used only by the registered address decode
  function automatic region_e region_of(input logic [15:0] a, input variant_e var_sel,
                                        input logic big);
    logic [15:0] rom_first;
    logic [15:0] ram_last;
    rom_first = (var_sel == VAR_MASK) ? ROM_FIRST_MASK :
                (var_sel == VAR_OTP)  ? ROM_FIRST_OTP  : ROM_FIRST_EXT;
    ram_last  = big ? RAM_LAST_LARGE : RAM_LAST_SMALL;
    if (a < RAM_FIRST) begin
      region_of = REGION_PERIPH; // RULE2
    end else if (a <= ram_last) begin
      region_of = REGION_RAM; // RULE2
    end else if (a >= rom_first) begin
      region_of = REGION_ROM; // RULE3
    end else begin
      region_of = REGION_NONE;
    end
  endfunction

  // Flat 64 KB decode, registered so data outputs come from flops
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_decode <= '{region: REGION_NONE, offset: 16'h0000};
    end else begin
      mem_decode.region <= region_of(mem_addr, rom_variant, large_ram); // RULE1
      mem_decode.offset <= mem_addr; // RULE1
    end
  end

  // Bank pointer masked to the bank count the RAM can hold
  logic [4:0] bank_eff;
  always_comb begin
    bank_eff = bank_select_pointer_ff[4:0] & (large_ram ? BANKS_LARGE_MAX
                                                        : BANKS_SMALL_MAX); // RULE18 RULE19
  end

  // Register address: base + bank*8 + number
  always_ff @(posedge clk) begin
    if (srst) begin
      gpr_addr <= BANK_BASE;
    end else begin
      gpr_addr <= BANK_BASE + {8'h00, bank_eff, gpr_num}; // RULE20
    end
  end

  // Program counter: reset vector, step, or software load
  always_ff @(posedge clk) begin
    if (srst) begin
      program_counter_ff <= PC_RESET; // RULE4
    end else if (reg_wr && reg_addr == IDX_PC) begin
      program_counter_ff <= reg_wdata; // RULE5
    end else if (pc_step) begin
      program_counter_ff <= program_counter_ff + 16'h0001; // RULE5
    end
  end

  // Arithmetic between the two accumulators and the flag results
  always_comb begin
    logic [8:0]  sum8;
    logic [4:0]  nib;
    logic [16:0] sum16;
    logic [7:0]  a8;
    logic [7:0]  t8;
    logic [7:0]  r8;
    a8 = work_accumulator_ff[7:0];
    t8 = second_operand_ff[7:0];
    sum8 = 9'h000;
    nib = 5'h00;
    sum16 = 17'h00000;
    r8 = 8'h00;
    nxt_acc = work_accumulator_ff;
    nxt_flags = condition_flags_ff;
    case (alu_op)
      ALU_ADD: begin
        sum8  = {1'b0, a8} + {1'b0, t8};
        nib   = {1'b0, a8[3:0]} + {1'b0, t8[3:0]};
        sum16 = {1'b0, work_accumulator_ff} + {1'b0, second_operand_ff};
        nxt_flags.h = nib[4]; // RULE11
        nxt_flags.v = (a8[7] == t8[7]) && (sum8[7] != a8[7]); // RULE16
        nxt_flags.c = sum8[8]; // RULE17
        r8 = sum8[7:0];
      end
      ALU_SUB: begin
        sum8  = {1'b0, a8} - {1'b0, t8};
        nib   = {1'b0, a8[3:0]} - {1'b0, t8[3:0]};
        sum16 = {1'b0, work_accumulator_ff} - {1'b0, second_operand_ff};
        nxt_flags.h = nib[4]; // RULE11
        nxt_flags.v = (a8[7] != t8[7]) && (sum8[7] != a8[7]); // RULE16
        nxt_flags.c = sum8[8]; // RULE17
        r8 = sum8[7:0];
      end
      ALU_SHL: begin
        r8 = {a8[6:0], 1'b0};
        nxt_flags.c = a8[7]; // RULE17
      end
      ALU_SHR: begin
        r8 = {1'b0, a8[7:1]};
        nxt_flags.c = a8[0]; // RULE17
      end
      default: begin
        r8 = a8;
      end
    endcase
    if (alu_op != ALU_NOP) begin
      nxt_flags.n = r8[7]; // RULE14
      nxt_flags.z = (r8 == 8'h00); // RULE15
      // Byte results leave the high byte alone; word add or sub replaces it
      nxt_acc = {work_accumulator_ff[15:8], r8}; // RULE6
      if (alu_word && (alu_op == ALU_ADD || alu_op == ALU_SUB)) begin
        nxt_acc = sum16[15:0];
      end
    end
  end

  // Work accumulator; no reset, contents undefined after reset
  always_ff @(posedge clk) begin
    if (reg_wr && reg_addr == IDX_ACC) begin
      work_accumulator_ff <= reg_wdata;
    end else if (alu_go) begin
      work_accumulator_ff <= nxt_acc; // RULE6
    end
  end

  // Second operand and pointer registers; deliberately unreset to save reset routing
  always_ff @(posedge clk) begin
    if (reg_wr) begin
      case (reg_addr)
        IDX_TMP: second_operand_ff       <= reg_wdata; // RULE7
        IDX_INDEX: index_register_ff       <= reg_wdata; // RULE8
        IDX_EXTRA: extra_memory_pointer_ff <= reg_wdata; // RULE9
        IDX_SP:  stack_top_pointer_ff    <= reg_wdata; // RULE9
        default: begin
        end
      endcase
    end
  end

  // Status word: bank pointer high, flags low
  always_ff @(posedge clk) begin
    if (srst) begin
      bank_select_pointer_ff <= 8'h00;
      condition_flags_ff     <= '{h: 1'b0, i: 1'b0, il: IL_RESET, n: 1'b0,
                                  z: 1'b0, v: 1'b0, c: 1'b0}; // RULE12 RULE13
    end else if (reg_wr && reg_addr == IDX_PSW) begin
      bank_select_pointer_ff <= reg_wdata[15:8]; // RULE10
      condition_flags_ff     <= flags_s'(reg_wdata[7:0]); // RULE10
    end else if (alu_go) begin
      condition_flags_ff     <= nxt_flags;
    end
  end

  // Interrupt gate: enabled and strictly higher priority than mask
  always_comb begin
    irq_take = irq_req && condition_flags_ff.i
               && (irq_level < condition_flags_ff.il); // RULE12 RULE13
  end

  assign flags = condition_flags_ff;

  // Read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        IDX_PC:  reg_rdata <= program_counter_ff;
        IDX_ACC: reg_rdata <= work_accumulator_ff;
        IDX_TMP: reg_rdata <= second_operand_ff;
        IDX_INDEX: reg_rdata <= index_register_ff;
        IDX_EXTRA: reg_rdata <= extra_memory_pointer_ff;
        IDX_SP:  reg_rdata <= stack_top_pointer_ff;
        IDX_PSW: reg_rdata <= {bank_select_pointer_ff, condition_flags_ff}; // RULE10
        IDX_MAP: reg_rdata <= gpr_addr;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Checks: control state after reset
  // Accumulators and pointers are left out on purpose, they stay unknown
  a_pc_reset: assert property (@(posedge clk) // RULE4
    srst |=> program_counter_ff == PC_RESET)
    else $error("program counter not at reset vector");
  a_ie_reset: assert property (@(posedge clk) // RULE12
    srst |=> !flags.i && flags.il == IL_RESET)
    else $error("interrupt control not reset");
  a_bank_reset: assert property (@(posedge clk) // RULE10
    srst |=> bank_select_pointer_ff == 8'h00)
    else $error("bank pointer not cleared");

  // Checks: program counter load and step; a load beats a step
  a_pc_step: assert property (@(posedge clk) disable iff (srst) // RULE5
    pc_step && !reg_wr
    |=> program_counter_ff == $past(program_counter_ff) + 16'h0001)
    else $error("program counter did not step");
  a_pc_load: assert property (@(posedge clk) disable iff (srst) // RULE5
    reg_wr && reg_addr == IDX_PC
    |=> program_counter_ff == $past(reg_wdata))
    else $error("program counter load lost");

  // Checks: status word split into bank pointer and flags
  a_psw_load: assert property (@(posedge clk) disable iff (srst) // RULE10
    reg_wr && reg_addr == IDX_PSW
    |=> bank_select_pointer_ff == $past(reg_wdata[15:8])
        && 8'(flags) == $past(reg_wdata[7:0]))
    else $error("status word load split wrong");

  // Checks: interrupt gate; level 00 is the most urgent
  a_irq_gate: assert property (@(posedge clk) disable iff (srst) // RULE13
    irq_take |-> flags.i && irq_level < flags.il)
    else $error("interrupt taken while masked");
  a_irq_block: assert property (@(posedge clk) disable iff (srst) // RULE12
    !flags.i |-> !irq_take)
    else $error("interrupt taken while disabled");
  a_irq_lowest: assert property (@(posedge clk) disable iff (srst) // RULE13
    flags.il == IL_RESET && irq_level == IL_RESET |-> !irq_take)
    else $error("lowest level passed lowest mask");

  // Checks: flags after an operation, judged from the stored result and the old operands
  // A same-cycle accumulator or status write wins, so all register write cycles are excluded
  a_zero_flag: assert property (@(posedge clk) disable iff (srst) // RULE15
    alu_go && alu_op != ALU_NOP && !reg_wr
    |=> flags.z == (work_accumulator_ff[7:0] == 8'h00))
    else $error("zero flag wrong");
  a_neg_flag: assert property (@(posedge clk) disable iff (srst) // RULE14
    alu_go && alu_op != ALU_NOP && !reg_wr
    |=> flags.n == work_accumulator_ff[7])
    else $error("negative flag wrong");
  a_add_carry: assert property (@(posedge clk) disable iff (srst) // RULE17
    alu_go && alu_op == ALU_ADD && !reg_wr
    |=> flags.c == (work_accumulator_ff[7:0] < $past(work_accumulator_ff[7:0])))
    else $error("add carry wrong");
  a_sub_borrow: assert property (@(posedge clk) disable iff (srst) // RULE17
    alu_go && alu_op == ALU_SUB && !reg_wr
    |=> flags.c == ($past(work_accumulator_ff[7:0]) < $past(second_operand_ff[7:0])))
    else $error("sub borrow wrong");
  a_half_add: assert property (@(posedge clk) disable iff (srst) // RULE11
    alu_go && alu_op == ALU_ADD && !reg_wr
    |=> flags.h == (work_accumulator_ff[3:0] < $past(work_accumulator_ff[3:0])))
    else $error("add half carry wrong");
  a_half_sub: assert property (@(posedge clk) disable iff (srst) // RULE11
    alu_go && alu_op == ALU_SUB && !reg_wr
    |=> flags.h == ($past(work_accumulator_ff[3:0]) < $past(second_operand_ff[3:0])))
    else $error("sub half borrow wrong");
  a_add_ovf: assert property (@(posedge clk) disable iff (srst) // RULE16
    alu_go && alu_op == ALU_ADD && !reg_wr
    |=> flags.v == ($past(work_accumulator_ff[7]) == $past(second_operand_ff[7])
                    && work_accumulator_ff[7] != $past(work_accumulator_ff[7])))
    else $error("add overflow wrong");
  a_shl_carry: assert property (@(posedge clk) disable iff (srst) // RULE17
    alu_go && alu_op == ALU_SHL && !reg_wr
    |=> flags.c == $past(work_accumulator_ff[7]))
    else $error("left shift carry wrong");
  a_shr_carry: assert property (@(posedge clk) disable iff (srst) // RULE17
    alu_go && alu_op == ALU_SHR && !reg_wr
    |=> flags.c == $past(work_accumulator_ff[0]))
    else $error("right shift carry wrong");
  a_shift_keep: assert property (@(posedge clk) disable iff (srst) // RULE17
    alu_go && (alu_op == ALU_SHL || alu_op == ALU_SHR) && !reg_wr
    |=> flags.h == $past(flags.h) && flags.v == $past(flags.v))
    else $error("shift touched half carry or overflow");

  // Checks: accumulator width handling
  a_byte_high: assert property (@(posedge clk) disable iff (srst) // RULE6
    alu_go && !alu_word && !reg_wr
    |=> work_accumulator_ff[15:8] == $past(work_accumulator_ff[15:8]))
    else $error("byte op touched high byte");
  a_word_add: assert property (@(posedge clk) disable iff (srst) // RULE7
    alu_go && alu_word && alu_op == ALU_ADD && !reg_wr
    |=> work_accumulator_ff == $past(work_accumulator_ff) + $past(second_operand_ff))
    else $error("word add result wrong");

  // Checks: address decode, one cycle behind the address
  a_periph_decode: assert property (@(posedge clk) disable iff (srst) // RULE2
    mem_addr <= PERIPH_LAST |=> mem_decode.region == REGION_PERIPH)
    else $error("peripheral range misdecoded");
  a_ram_decode: assert property (@(posedge clk) disable iff (srst) // RULE2
    mem_addr == RAM_FIRST |=> mem_decode.region == REGION_RAM)
    else $error("ram start misdecoded");
  a_rom_decode: assert property (@(posedge clk) disable iff (srst) // RULE3
    mem_addr >= ROM_FIRST_MASK |=> mem_decode.region == REGION_ROM)
    else $error("top of map not program memory");
  a_offset_pass: assert property (@(posedge clk) disable iff (srst) // RULE1
    1'b1 |=> mem_decode.offset == $past(mem_addr))
    else $error("decoded offset lost");

  // Checks: register bank address
  a_bank_addr: assert property (@(posedge clk) disable iff (srst) // RULE20
    1'b1 |=> gpr_addr[2:0] == $past(gpr_num))
    else $error("register number lost");
  a_bank_small: assert property (@(posedge clk) disable iff (srst) // RULE18
    !large_ram |=> gpr_addr[15:7] == 9'h002)
    else $error("bank beyond small ram count");
  a_bank_large: assert property (@(posedge clk) disable iff (srst) // RULE19
    large_ram |=> gpr_addr[7:3] == $past(bank_select_pointer_ff[4:0]))
    else $error("large ram bank lost");

  // Checks: read port idles at zero between reads
  a_rd_idle: assert property (@(posedge clk) disable iff (srst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");

  c_add: cover property (@(posedge clk) alu_go && alu_op == ALU_ADD);
  c_irq: cover property (@(posedge clk) irq_take);
  c_rom: cover property (@(posedge clk) mem_decode.region == REGION_ROM);
  c_word: cover property (@(posedge clk) alu_go && alu_word);
  c_bank_large: cover property (@(posedge clk) large_ram && bank_select_pointer_ff[4]);

endmodule

`default_nettype wire

// File: test/irq_source.sv
// Interrupt source model sitting in front of the core's interrupt gate
`timescale 1ns/100ps
`default_nettype none

module irq_source (
  input  wire logic       clk,
  input  wire logic       want,
  input  wire logic [1:0] want_level,
  output logic            irq_req,
  output logic [1:0]      irq_level
);
  // Level means nothing while idle, so show a wrong one then
  always_ff @(posedge clk) begin
    irq_req   <= want;
    irq_level <= want ? want_level : ~want_level;
  end
endmodule

`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the core state block
`timescale 1ns/100ps
`default_nettype none

module tb;
  import core_state_pkg::*;
  logic        clk, srst, large_ram, reg_wr, reg_rd, pc_step, alu_go, alu_word;
  logic        want, irq_req, irq_take;
  variant_e    rom_variant;
  alu_op_e     alu_op;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, mem_addr, gpr_addr, rv;
  logic [2:0]  gpr_num;
  logic [1:0]  want_level, irq_level;
  decode_s     mem_decode;
  flags_s      flags;
  int          bad_count, comparisons;

  core_state dut (.clk(clk), .srst(srst), .rom_variant(rom_variant),
    .large_ram(large_ram), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc_step(pc_step),
    .alu_go(alu_go), .alu_op(alu_op), .alu_word(alu_word), .mem_addr(mem_addr),
    .mem_decode(mem_decode), .gpr_num(gpr_num), .gpr_addr(gpr_addr),
    .irq_req(irq_req), .irq_level(irq_level), .irq_take(irq_take), .flags(flags));
  irq_source src (.clk(clk), .want(want), .want_level(want_level),
    .irq_req(irq_req), .irq_level(irq_level));

  // Free running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("counts: %0d compared, %0d bad", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Bus cycles: one strobe cycle each, read data in the following cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic do_reset;
    @(posedge clk);
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
  endtask

  task automatic t_reset;
    rd(IDX_PC, rv);
    check(rv, PC_RESET);
    rd(IDX_PSW, rv);
    check(rv, 16'h0030);
    rd(IDX_MAP, rv);
    check(rv, BANK_BASE);
    rd(4'h8, rv);
    check(rv, 16'h0000);
    $display("test reset done");
  endtask

  // Writes with an idle cycle between them, then read back, plus program counter stepping
  task automatic t_regs;
    for (int i = 1; i < 6; i++) wr(4'(i), 16'h1111 * i[15:0] + 16'h00a5);
    wr(IDX_MAP, 16'hffff);
    for (int i = 1; i < 6; i++) begin
      rd(4'(i), rv);
      check(rv, 16'h1111 * i[15:0] + 16'h00a5);
    end
    rd(IDX_MAP, rv);
    check(rv, BANK_BASE);
    wr(IDX_PC, 16'h1234);
    @(posedge clk);
    pc_step <= 1'b1;
    @(posedge clk);
    pc_step <= 1'b0;
    rd(IDX_PC, rv);
    check(rv, 16'h1235);
    $display("test regs done");
  endtask

  task automatic t_alu;
    alu_op_e    op_t[7] = '{ALU_ADD, ALU_ADD, ALU_ADD, ALU_SUB, ALU_SHL, ALU_SHR, ALU_ADD};
    logic [7:0] a_t[7]  = '{8'h08, 8'h80, 8'h7f, 8'h10, 8'h81, 8'h01, 8'hff};
    logic [7:0] b_t[7]  = '{8'h08, 8'h80, 8'h01, 8'h10, 8'h00, 8'h00, 8'h01};
    logic [7:0] r_t[7]  = '{8'h10, 8'h00, 8'h80, 8'h00, 8'h02, 8'h00, 8'h00};
    logic [7:0] f_t[7]  = '{8'h80, 8'h07, 8'h8a, 8'h04, 8'h01, 8'h05, 8'h85};
    wr(IDX_PSW, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      wr(IDX_ACC, {8'hab, a_t[i]});
      wr(IDX_TMP, {8'h5a, b_t[i]});
      @(posedge clk);
      alu_go   <= 1'b1;
      alu_op   <= op_t[i];
      alu_word <= 1'b0;
      @(posedge clk);
      alu_go   <= 1'b0;
      #1 check({8'h00, flags}, {8'h00, f_t[i]});
      rd(IDX_ACC, rv);
      check(rv, {8'hab, r_t[i]});
    end
    // Word add carries into the high byte while flags stay byte based
    wr(IDX_ACC, 16'h00ff);
    wr(IDX_TMP, 16'h0001);
    @(posedge clk);
    alu_go   <= 1'b1;
    alu_op   <= ALU_ADD;
    alu_word <= 1'b1;
    @(posedge clk);
    alu_go   <= 1'b0;
    alu_word <= 1'b0;
    #1 check({8'h00, flags}, 16'h0085);
    rd(IDX_ACC, rv);
    check(rv, 16'h0100);
    $display("test alu done");
  endtask

  task automatic t_map;
    variant_e    v_t[13] = '{VAR_MASK, VAR_MASK, VAR_MASK, VAR_MASK, VAR_MASK, VAR_MASK,
                             VAR_MASK, VAR_MASK, VAR_OTP, VAR_OTP, VAR_EXT, VAR_EXT, VAR_MASK};
    logic        l_t[13] = '{0, 0, 0, 0, 1, 1, 0, 0, 0, 0, 0, 0, 0};
    logic [15:0] a_t[13] = '{16'h007f, 16'h0080, 16'h027f, 16'h0280, 16'h047f, 16'h0480,
                             16'hdfff, 16'he000, 16'hc000, 16'hbfff, 16'h8000, 16'h7fff,
                             16'hffff};
    region_e     g_t[13] = '{REGION_PERIPH, REGION_RAM, REGION_RAM, REGION_NONE, REGION_RAM,
                             REGION_NONE, REGION_NONE, REGION_ROM, REGION_ROM, REGION_NONE,
                             REGION_ROM, REGION_NONE, REGION_ROM};
    for (int i = 0; i < 13; i++) begin
      @(posedge clk);
      rom_variant <= v_t[i];
      large_ram   <= l_t[i];
      mem_addr    <= a_t[i];
      @(posedge clk);
      #1 check({13'h0000, mem_decode.region}, {13'h0000, g_t[i]});
      check(mem_decode.offset, a_t[i]);
    end
    large_ram   <= 1'b0;
    rom_variant <= VAR_MASK;
    $display("test map done");
  endtask

  task automatic t_bank;
    wr(IDX_PSW, 16'h0500);
    gpr_num <= 3'h3;
    rd(IDX_PSW, rv);
    check(rv, 16'h0500);
    @(posedge clk);
    #1 check(gpr_addr, 16'h012b);
    wr(IDX_PSW, 16'h1f00);
    gpr_num <= 3'h7;
    repeat (2) @(posedge clk);
    #1 check(gpr_addr, 16'h017f);
    large_ram <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check(gpr_addr, 16'h01ff);
    large_ram <= 1'b0;
    $display("test bank done");
  endtask

  task automatic t_irq;
    logic [7:0] p_t[5] = '{8'h00, 8'h70, 8'h70, 8'h50, 8'h50};
    logic [1:0] l_t[5] = '{2'h0, 2'h2, 2'h3, 2'h0, 2'h1};
    logic       e_t[5] = '{0, 1, 0, 1, 0};
    for (int i = 0; i < 5; i++) begin
      wr(IDX_PSW, {8'h00, p_t[i]});
      want       <= 1'b1;
      want_level <= l_t[i];
      repeat (2) @(posedge clk);
      #1 check({15'h0000, irq_take}, {15'h0000, e_t[i]});
    end
    want <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check({15'h0000, irq_take}, 16'h0000);
    $display("test irq done");
  endtask

  // Watchdog: the whole run needs well under 2000 cycles
  initial begin
    #200000;
    bad_count++;
    final_report;
  end

  initial begin
    {srst, large_ram, reg_wr, reg_rd, pc_step, alu_go, alu_word, want} = '0;
    rom_variant = VAR_MASK;
    alu_op      = ALU_NOP;
    reg_addr    = 4'h0;
    reg_wdata   = 16'h0000;
    mem_addr    = 16'h0000;
    gpr_num     = 3'h0;
    want_level  = 2'h0;
    bad_count   = 0;
    comparisons = 0;
    do_reset;
    t_reset;
    t_regs;
    t_alu;
    t_map;
    t_bank;
    t_irq;
    // Second reset in mid-run must restore the same state
    do_reset;
    gpr_num <= 3'h0;
    t_reset;
    final_report;
  end
endmodule

`default_nettype wire
